// ==== core/adic_pkg.sv ====
// constants and types for the audio decoder io and clocking block
package adic_pkg;
    localparam logic [5:0] CTRL_OFS   = 6'h00;
    localparam logic [5:0] STATUS_OFS = 6'h04;
    localparam logic [5:0] GAIN_OFS   = 6'h08;
    localparam logic [5:0] TONE_OFS   = 6'h18;
    localparam logic [5:0] MADDR_OFS  = 6'h1c;
    localparam logic [5:0] MDATA_OFS  = 6'h20;
    localparam logic [5:0] RUN_OFS    = 6'h24;
    localparam logic [5:0] AUDL_OFS   = 6'h28;
    localparam logic [5:0] AUDR_OFS   = 6'h2c;
    localparam logic [5:0] OUTL_OFS   = 6'h30;
    localparam logic [5:0] OUTR_OFS   = 6'h34;
    localparam logic [5:0] BITS_OFS   = 6'h38;
    localparam int C_BCAST  = 0;
    localparam int C_MUTE   = 1;
    localparam int C_BYPASS = 2;
    localparam int C_PSEL   = 3;
    localparam int C_VER    = 4;
    localparam int C_FAM    = 6;
    localparam int C_REF    = 7;
    localparam int C_CRC    = 8;
    localparam int S_OVF    = 4;
    localparam int S_UNF    = 5;
    localparam logic [8:0]  CTRL_RST  = 9'h000;
    localparam logic [19:0] UNITY     = 20'h7ffff;
    localparam logic [11:0] SYNC_WORD = 12'hfff;
    localparam int DW           = 20;
    localparam int ACC_W        = 32;
    localparam int BASS_SHIFT   = 7;
    localparam int TREBLE_SHIFT = 2;
    localparam int PRESCALE     = 1;
    localparam int SYNC_DELAY   = 2;
    localparam int PROG_WORDS   = 1024;
    typedef enum logic [0:0] {PG_IDLE = 1'b0, PG_RUN = 1'b1} adic_prog_type;
endpackage

// ==== core/adic_mix_if.sv ====
// signals between the register core and the audio processing stage
`timescale 1ns/100ps
interface adic_mix_if;
    logic signed [19:0] in_l;
    logic signed [19:0] in_r;
    logic signed [19:0] gain [4];
    logic signed [4:0]  bass;
    logic signed [4:0]  treble;
    logic        [1:0]  version;
    logic               mute;
    logic               bypass;
    logic               strobe;
    logic               halt;
    logic signed [19:0] out_l;
    logic signed [19:0] out_r;
    modport proc (input in_l, in_r, gain, bass, treble, version, mute, bypass,
                  strobe, halt, output out_l, out_r);
    modport ctrl (output in_l, in_r, gain, bass, treble, version, mute, bypass,
                  strobe, halt, input out_l, out_r);
endinterface

// ==== core/adic_mix.sv ====
// volume matrix, tone stage, mute and bypass for one stereo pair
`timescale 1ns/100ps
module adic_mix
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // audio path
    adic_mix_if.proc mx
);
    logic signed [19:0] in_v   [2];
    logic signed [31:0] acc    [2];
    logic signed [19:0] mix    [2];
    logic signed [31:0] tone   [2];
    logic signed [19:0] sat    [2];
    logic signed [19:0] blp_q  [2];
    logic signed [19:0] tlp_q  [2];
    logic signed [19:0] res_q  [2];
    logic signed [19:0] outv_q [2];
    logic        [3:0]  bshift;
    logic               boost;

    assign in_v[0] = mx.in_l;
    assign in_v[1] = mx.in_r;
    assign bshift  = 4'(adic_pkg::BASS_SHIFT) - {2'b00, mx.version};
    assign boost   = (mx.bass > 5'sd0) || (mx.treble > 5'sd0);
    assign mx.out_l = outv_q[0];
    assign mx.out_r = outv_q[1];

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        always_comb
        begin
            // 40-bit products trimmed into a 32-bit accumulator
            acc[c] = 32'((41'(in_v[0]) * 41'(mx.gain[c])
                        + 41'(in_v[1]) * 41'(mx.gain[2 + c])) >>> 8);
            mix[c] = 20'(acc[c] >>> 11);
            tone[c] = 32'(mix[c])
                    + ((32'(mx.bass) * 32'(blp_q[c])) >>> 4)
                    + ((32'(mx.treble) * 32'(mix[c] - tlp_q[c])) >>> 4);
            if (boost)
            begin
                tone[c] = tone[c] >>> adic_pkg::PRESCALE;
            end
            if (tone[c] > 32'sd524287)
            begin
                sat[c] = 20'sh7ffff;
            end
            else if (tone[c] < -32'sd524288)
            begin
                sat[c] = 20'sh80000;
            end
            else
            begin
                sat[c] = 20'(tone[c]);
            end
        end

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                blp_q[c] <= '0;
                tlp_q[c] <= '0;
                res_q[c] <= '0;
            end
            else if (mx.strobe)
            begin
                blp_q[c] <= blp_q[c] + ((mix[c] - blp_q[c]) >>> bshift);
                tlp_q[c] <= tlp_q[c] + ((mix[c] - tlp_q[c]) >>> adic_pkg::TREBLE_SHIFT);
                res_q[c] <= mx.bypass ? in_v[c] : sat[c];
            end
        end

        // mute acts on the output stage so filter state and gains survive
        always_ff @(posedge clk)
        begin
            if (rst || mx.mute || mx.halt)
            begin
                outv_q[c] <= '0;
            end
            else
            begin
                outv_q[c] <= res_q[c];
            end
        end
    end
endmodule

// ==== core/adic_top.sv ====
// bitstream intake, program download, audio regs and clock generation
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module adic_top
#(
    parameter int BUF_DEPTH  = 16,
    parameter int LOW_MARK   = 4,
    parameter int MCLK_HALF  = 1,
    parameter int SAMPLE_HALF = 200
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // bitstream pins
    input  wire logic        bitstream_clock_in,
    input  wire logic        bitstream_data_in,
    input  wire logic        bitstream_aux_in,
    output logic             data_demand_out,
    // indicators
    output logic             frame_sync_out,
    output logic             crc_error_out,
    // clocking
    input  wire logic        scaler_select_pin,
    output logic             master_clock_out,
    output logic             sample_clock_out
);
    localparam int PW = $clog2(BUF_DEPTH);

    adic_mix_if mx ();

    logic [3:0]   sy1_q;
    logic [3:0]   sy2_q;
    logic         sic_prev_q;
    logic         fall;
    logic [8:0]   ctrl_q;
    logic [19:0]  gain_q [4];
    logic [9:0]   tone_q;
    logic [19:0]  aud_l_q;
    logic [19:0]  aud_r_q;
    logic         strobe_q;
    logic [31:0]  rdata_d;
    logic [31:0]  rdata_q;
    logic         wait_q;
    logic         wr_ok;
    logic         rd_ok;
    logic [15:0]  shift_q;
    logic [3:0]   bitcnt_q;
    logic [15:0]  buf_mem [BUF_DEPTH];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0]  level_q;
    logic         full;
    logic         push;
    logic         pop;
    logic         demand_q;
    logic         fsync_q;
    logic         crc_q;
    logic         ovf_q;
    logic         unf_q;
    logic [19:0]  prog_mem [adic_pkg::PROG_WORDS];
    logic [9:0]   maddr_q;
    logic [9:0]   pc_q;
    logic [19:0]  fetch_q;
    typedef adic_pkg::adic_prog_type adic_prog_state_type;
    adic_prog_state_type state_q;
    logic [1:0]   latch_cnt_q;
    logic         latched_q;
    logic         scaler_q;
    logic [5:0]   mdiv_q;
    logic [5:0]   mhalf;
    logic         mclk_q;
    logic [15:0]  meas_q;
    logic [15:0]  period_q;
    logic [19:0]  sdiv_q;
    logic [19:0]  shalf;
    logic         sclk_q;

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign data_demand_out = demand_q;
    assign frame_sync_out  = fsync_q;
    assign crc_error_out   = crc_q;
    assign master_clock_out = mclk_q;
    assign sample_clock_out = sclk_q;

    // two-stage synchronisers: clock, data, aux, scaler pin
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sy1_q      <= '0;
            sy2_q      <= '0;
            sic_prev_q <= 1'b0;
        end
        else
        begin
            sy1_q      <= {scaler_select_pin, bitstream_aux_in,
                           bitstream_data_in, bitstream_clock_in};
            sy2_q      <= sy1_q;
            sic_prev_q <= sy2_q[0];
        end
    end

    assign fall = sic_prev_q & ~sy2_q[0];

    // bus handshake: one wait cycle, access completes when waitrequest is low
    assign wr_ok = avs_write & ~wait_q;
    assign rd_ok = avs_read & ~wait_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end
        else if ((avs_read || avs_write) && wait_q)
        begin
            wait_q  <= 1'b0;
            rdata_q <= rdata_d;
        end
        else
        begin
            wait_q <= 1'b1;
        end
    end

    always_comb
    begin
        rdata_d = '0;
        if (avs_address == adic_pkg::CTRL_OFS)
        begin
            rdata_d = {23'h0, ctrl_q};
        end
        else if (avs_address == adic_pkg::STATUS_OFS)
        begin
            rdata_d = {16'h0, 8'(level_q), full, sy2_q[2], unf_q, ovf_q,
                       scaler_q, state_q == adic_pkg::PG_RUN, fsync_q, demand_q};
        end
        else if (avs_address >= adic_pkg::GAIN_OFS && avs_address < adic_pkg::TONE_OFS)
        begin
            rdata_d = {12'h0, gain_q[avs_address[3:2] - 2'h2]};
        end
        else if (avs_address == adic_pkg::TONE_OFS)
        begin
            rdata_d = {19'h0, tone_q[9:5], 3'h0, tone_q[4:0]};
        end
        else if (avs_address == adic_pkg::MADDR_OFS)
        begin
            rdata_d = {22'h0, maddr_q};
        end
        else if (avs_address == adic_pkg::MDATA_OFS)
        begin
            rdata_d = {12'h0, prog_mem[maddr_q]};
        end
        else if (avs_address == adic_pkg::RUN_OFS)
        begin
            rdata_d = {2'h0, fetch_q, pc_q};
        end
        else if (avs_address == adic_pkg::OUTL_OFS)
        begin
            rdata_d = {12'h0, mx.out_l};
        end
        else if (avs_address == adic_pkg::OUTR_OFS)
        begin
            rdata_d = {12'h0, mx.out_r};
        end
        else if (avs_address == adic_pkg::BITS_OFS)
        begin
            rdata_d = {15'h0, level_q != '0, buf_mem[rp_q]};
        end
    end

    // control, gains, tone and audio sample registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_q    <= adic_pkg::CTRL_RST;
            gain_q[0] <= adic_pkg::UNITY;
            gain_q[1] <= '0;
            gain_q[2] <= '0;
            gain_q[3] <= adic_pkg::UNITY;
            tone_q    <= '0;
            aud_l_q   <= '0;
            aud_r_q   <= '0;
            strobe_q  <= 1'b0;
        end
        else
        begin
            strobe_q <= wr_ok && avs_address == adic_pkg::AUDR_OFS;
            if (wr_ok && avs_address == adic_pkg::CTRL_OFS)
            begin
                ctrl_q <= avs_writedata[8:0];
            end
            else if (wr_ok && avs_address >= adic_pkg::GAIN_OFS
                     && avs_address < adic_pkg::TONE_OFS)
            begin
                gain_q[avs_address[3:2] - 2'h2] <= avs_writedata[19:0];
            end
            else if (wr_ok && avs_address == adic_pkg::TONE_OFS)
            begin
                tone_q <= {avs_writedata[12:8], avs_writedata[4:0]};
            end
            else if (wr_ok && avs_address == adic_pkg::AUDL_OFS)
            begin
                aud_l_q <= avs_writedata[19:0];
            end
            else if (wr_ok && avs_address == adic_pkg::AUDR_OFS)
            begin
                aud_r_q <= avs_writedata[19:0];
            end
        end
    end

    // serial intake and word buffer
    assign full = level_q == (PW+1)'(BUF_DEPTH);
    assign pop  = rd_ok && avs_address == adic_pkg::BITS_OFS && level_q != '0;
    assign push = fall && bitcnt_q == 4'hf && !full && state_q == adic_pkg::PG_IDLE
                  && (ctrl_q[adic_pkg::C_BCAST] || demand_q);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shift_q  <= '0;
            bitcnt_q <= '0;
        end
        else if (fall && state_q == adic_pkg::PG_IDLE
                 && (ctrl_q[adic_pkg::C_BCAST] || demand_q))
        begin
            shift_q  <= {shift_q[14:0], sy2_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            buf_mem[wp_q] <= {shift_q[14:0], sy2_q[1]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp_q    <= '0;
            rp_q    <= '0;
            level_q <= '0;
        end
        else
        begin
            wp_q    <= wp_q + PW'(push);
            rp_q    <= rp_q + PW'(pop);
            level_q <= level_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // demand with hysteresis: refill from low mark to full
    always_ff @(posedge clk)
    begin
        if (rst || ctrl_q[adic_pkg::C_BCAST] || state_q == adic_pkg::PG_RUN)
        begin
            demand_q <= 1'b0;
        end
        else if (full || (push && level_q == (PW+1)'(BUF_DEPTH - 1)))
        begin
            demand_q <= 1'b0;
        end
        else if (level_q < (PW+1)'(LOW_MARK))
        begin
            demand_q <= 1'b1;
        end
    end

    // flags: hardware set wins over write-one-to-clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fsync_q <= 1'b0;
            crc_q   <= 1'b0;
            ovf_q   <= 1'b0;
            unf_q   <= 1'b0;
        end
        else
        begin
            crc_q <= ctrl_q[adic_pkg::C_CRC];
            if (push && shift_q[14:3] == adic_pkg::SYNC_WORD)
            begin
                fsync_q <= 1'b1;
            end
            else if (rd_ok && avs_address == adic_pkg::BITS_OFS && level_q == '0)
            begin
                fsync_q <= 1'b0;
            end
            if (fall && bitcnt_q == 4'hf && full)
            begin
                ovf_q <= 1'b1;
            end
            else if (wr_ok && avs_address == adic_pkg::STATUS_OFS
                     && avs_writedata[adic_pkg::S_OVF])
            begin
                ovf_q <= 1'b0;
            end
            // an empty buffer is the only fault a late source can cause
            if (rd_ok && avs_address == adic_pkg::BITS_OFS && level_q == '0)
            begin
                unf_q <= 1'b1;
            end
            else if (wr_ok && avs_address == adic_pkg::STATUS_OFS
                     && avs_writedata[adic_pkg::S_UNF])
            begin
                unf_q <= 1'b0;
            end
        end
    end

    // download ram and run control
    always_ff @(posedge clk)
    begin
        if (wr_ok && avs_address == adic_pkg::MDATA_OFS)
        begin
            prog_mem[maddr_q] <= avs_writedata[19:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            maddr_q <= '0;
        end
        else if (wr_ok && avs_address == adic_pkg::MADDR_OFS)
        begin
            maddr_q <= avs_writedata[9:0];
        end
        else if (wr_ok && avs_address == adic_pkg::MDATA_OFS)
        begin
            maddr_q <= maddr_q + 10'h1;
        end
    end

    // execution stand-in: fetches through the ram region while running
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= adic_pkg::PG_IDLE;
            pc_q    <= '0;
            fetch_q <= '0;
        end
        else
        begin
            case (state_q)
                adic_pkg::PG_IDLE:
                begin
                    if (wr_ok && avs_address == adic_pkg::RUN_OFS
                        && ctrl_q[adic_pkg::C_PSEL])
                    begin
                        state_q <= adic_pkg::PG_RUN;
                        pc_q    <= avs_writedata[9:0];
                    end
                end
                default:
                begin
                    fetch_q <= prog_mem[pc_q];
                    pc_q    <= pc_q + 10'h1;
                    if (!ctrl_q[adic_pkg::C_PSEL])
                    begin
                        state_q <= adic_pkg::PG_IDLE;
                    end
                end
            endcase
        end
    end

    // audio processing stage
    assign mx.in_l    = aud_l_q;
    assign mx.in_r    = aud_r_q;
    assign mx.gain[0] = gain_q[0];
    assign mx.gain[1] = gain_q[1];
    assign mx.gain[2] = gain_q[2];
    assign mx.gain[3] = gain_q[3];
    assign mx.bass    = tone_q[4:0];
    assign mx.treble  = tone_q[9:5];
    assign mx.version = ctrl_q[adic_pkg::C_VER +: 2];
    assign mx.mute    = ctrl_q[adic_pkg::C_MUTE];
    assign mx.bypass  = ctrl_q[adic_pkg::C_BYPASS];
    assign mx.strobe  = strobe_q;
    assign mx.halt    = state_q == adic_pkg::PG_RUN;

    adic_mix u_mix
    (
        .clk (clk),
        .rst (rst),
        .mx  (mx)
    );

    // scaler choice caught once, after the pin has passed the synchroniser
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            latch_cnt_q <= '0;
            latched_q   <= 1'b0;
            scaler_q    <= 1'b0;
        end
        else if (!latched_q)
        begin
            latch_cnt_q <= latch_cnt_q + 2'h1;
            if (latch_cnt_q == 2'(adic_pkg::SYNC_DELAY))
            begin
                scaler_q  <= ~sy2_q[3];
                latched_q <= 1'b1;
            end
        end
    end

    // master clock: low pin level enables the divide by 1, 2, 4 or 8
    assign mhalf = 6'(MCLK_HALF) << (scaler_q ? ctrl_q[adic_pkg::C_VER +: 2] : 2'h0);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mdiv_q <= '0;
            mclk_q <= 1'b0;
        end
        else if (mdiv_q >= mhalf - 6'h1)
        begin
            mdiv_q <= '0;
            mclk_q <= ~mclk_q;
        end
        else
        begin
            mdiv_q <= mdiv_q + 6'h1;
        end
    end

    // digital pll: in broadcast mode the filtered bit period scales the sample clock
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meas_q   <= '0;
            period_q <= '0;
        end
        else if (fall)
        begin
            meas_q   <= '0;
            period_q <= period_q + 16'(($signed({1'b0, meas_q})
                        - $signed({1'b0, period_q})) >>> 2);
        end
        else if (meas_q != 16'hffff)
        begin
            meas_q <= meas_q + 16'h1;
        end
    end

    assign shalf = ctrl_q[adic_pkg::C_BCAST] ? {period_q, 4'h0} : 20'(SAMPLE_HALF);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sdiv_q <= '0;
            sclk_q <= 1'b0;
        end
        else if (sdiv_q >= shalf - 20'h1)
        begin
            sdiv_q <= '0;
            sclk_q <= ~sclk_q;
        end
        else
        begin
            sdiv_q <= sdiv_q + 20'h1;
        end
    end
endmodule

// ==== verif/adic_top_monitor.sv ====
// port checker for the decoder io block
`timescale 1ns/100ps
module adic_top_monitor
#(
    parameter int SAMPLE_HALF = 200
)
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register bus
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // pins
    input wire logic        data_demand_out,
    input wire logic        crc_error_out,
    input wire logic        master_clock_out,
    input wire logic        sample_clock_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state not exactly one cycle");
    property p_idle;
        !avs_read && !avs_write |=> avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("waitrequest low without request");
    property p_hold;
        $rose(avs_waitrequest) |-> avs_readdata == $past(avs_readdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data did not hold");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > 6'h38 |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_crc;
        avs_write && !avs_waitrequest && avs_address == adic_pkg::CTRL_OFS |=> ##1
            crc_error_out == $past(avs_writedata[adic_pkg::C_CRC], 2);
    endproperty
    a_crc: assert property (p_crc) else $error("crc pin not following control");
    property p_dem;
        $fell(rst) |-> ##[1:3] data_demand_out;
    endproperty
    a_dem: assert property (p_dem) else $error("demand not raised after reset");
    // version stays 0 in the bench, so the clock toggles each cycle either way
    property p_mclk;
        !rst [*4] |=> master_clock_out != $past(master_clock_out);
    endproperty
    a_mclk: assert property (p_mclk) else $error("master clock divided");
    property p_sclk;
        $changed(sample_clock_out) |=> $stable(sample_clock_out) [*8];
    endproperty
    a_sclk: assert property (p_sclk) else $error("sample clock too fast");
endmodule
bind adic_top adic_top_monitor #(.SAMPLE_HALF(SAMPLE_HALF)) i_mon (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .data_demand_out(data_demand_out),
    .crc_error_out(crc_error_out), .master_clock_out(master_clock_out),
    .sample_clock_out(sample_clock_out));

// ==== verif/adic_src.sv ====
// bitstream source that starts a bit only while demand is high
`timescale 1ns/100ps
module adic_src
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // control
    input  wire logic        en,
    input  wire logic [15:0] word,
    input  wire logic        demand,
    // bitstream pins
    output logic             sclk,
    output logic             sdata,
    output logic             aux
);
    logic [3:0] ph_q;
    logic [3:0] bit_q;
    assign aux = 1'b0;
    // ten clocks a bit, well above the data rate
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ph_q <= 4'h0;
            bit_q <= 4'h0;
            sclk <= 1'b1;
        end
        else if (ph_q == 4'h0)
        begin
            if (en && demand)
                ph_q <= 4'h1;
        end
        else
        begin
            ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
            bit_q <= (ph_q == 4'h9) ? bit_q + 4'h1 : bit_q;
            sclk <= (ph_q == 4'h4) ? 1'b0 : (ph_q == 4'h8) ? 1'b1 : sclk;
        end
    end
    // idle data toggles so no stale bit can pass for a real one
    always_ff @(posedge clk)
        sdata <= (ph_q == 4'h0) ? ((en && demand) ? word[~bit_q] : ~sdata) : sdata;
endmodule

// ==== verif/tb_audio_decoder_io_and_clocking.sv ====
// self-checking bench for the decoder io block
`timescale 1ns/100ps
module tb_audio_decoder_io_and_clocking;
    logic        clk, rst, rd, wr, sck, sda, aux, dem, fs, crc, pin, mck, smp, wrq, en;
    logic [5:0]  adr;
    logic [31:0] wd, rdt, rv;
    int          err_total, num_checks;
    adic_top #(.BUF_DEPTH(4), .LOW_MARK(1), .SAMPLE_HALF(10)) i_dut (.clk(clk), .rst(rst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdt), .avs_waitrequest(wrq), .bitstream_clock_in(sck),
        .bitstream_data_in(sda), .bitstream_aux_in(aux), .data_demand_out(dem),
        .frame_sync_out(fs), .crc_error_out(crc), .scaler_select_pin(pin),
        .master_clock_out(mck), .sample_clock_out(smp));
    adic_src i_src (.clk(clk), .rst(rst), .en(en), .word(16'hfff0), .demand(dem),
        .sclk(sck), .sdata(sda), .aux(aux));
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a; wd <= d; rd <= !w; wr <= w;
        @(posedge clk);
        while (wrq !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (wrq !== 1'b0) err_total++;
        rv = rdt;
        rd <= 1'b0; wr <= 1'b0;
        // one idle edge, so a following call never re-raises in the same step
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rchk(input string s, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(s, e, rv);
    endtask
    task automatic t_reset();
        rchk("ctrl", adic_pkg::CTRL_OFS, 32'h0);
        rchk("gain ll", adic_pkg::GAIN_OFS, {12'h0, adic_pkg::UNITY});
        rchk("gain rr", 6'h14, {12'h0, adic_pkg::UNITY});
        rchk("unmapped", 6'h3c, 32'h0);
        pin <= 1'b0;
        repeat (5) @(posedge clk);
        bus(1'b0, adic_pkg::STATUS_OFS, 32'h0);
        chk("scaler held", 32'h0, {31'h0, rv[3]});
        $display("reset test done");
    endtask
    task automatic t_stream();
        int n;
        en <= 1'b1;
        for (n = 0; n < 3000 && dem !== 1'b0; n++) @(posedge clk);
        en <= 1'b0;
        chk("demand full", 32'h0, {31'h0, dem});
        chk("frame sync", 32'h1, {31'h0, fs});
        for (n = 0; n < 4; n++) rchk("bits", adic_pkg::BITS_OFS, 32'h1fff0);
        repeat (4) @(posedge clk);
        chk("demand empty", 32'h1, {31'h0, dem});
        bus(1'b0, adic_pkg::BITS_OFS, 32'h0);
        chk("bits empty", 32'h0, {31'h0, rv[16]});
        chk("sync cleared", 32'h0, {31'h0, fs});
        bus(1'b0, adic_pkg::STATUS_OFS, 32'h0);
        chk("underflow", 32'h1, {31'h0, rv[5]});
        $display("stream test done");
    endtask
    task automatic t_audio();
        bus(1'b1, 6'h0c, 32'h01234);
        rchk("gain lr", 6'h0c, 32'h01234);
        bus(1'b1, adic_pkg::CTRL_OFS, 32'h4);
        bus(1'b1, adic_pkg::AUDL_OFS, 32'h12345);
        bus(1'b1, adic_pkg::AUDR_OFS, 32'h0abcd);
        repeat (3) @(posedge clk);
        rchk("bypass l", adic_pkg::OUTL_OFS, 32'h12345);
        rchk("bypass r", adic_pkg::OUTR_OFS, 32'h0abcd);
        bus(1'b1, adic_pkg::CTRL_OFS, 32'h6);
        rchk("mute l", adic_pkg::OUTL_OFS, 32'h0);
        rchk("gain kept", 6'h0c, 32'h01234);
        $display("audio test done");
    endtask
    task automatic t_prog();
        bus(1'b1, adic_pkg::CTRL_OFS, 32'h108);
        bus(1'b1, adic_pkg::MADDR_OFS, 32'h0);
        bus(1'b1, adic_pkg::MDATA_OFS, 32'h54321);
        bus(1'b1, adic_pkg::MADDR_OFS, 32'h0);
        rchk("ram word", adic_pkg::MDATA_OFS, 32'h54321);
        bus(1'b1, adic_pkg::RUN_OFS, 32'h0);
        bus(1'b0, adic_pkg::STATUS_OFS, 32'h0);
        chk("running", 32'h2, {30'h0, rv[2], rv[0]});
        chk("crc pin", 32'h1, {31'h0, crc});
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b0, adic_pkg::STATUS_OFS, 32'h0);
        chk("scaler on", 32'h1, {31'h0, rv[3]});
        chk("crc cleared", 32'h0, {31'h0, crc});
        $display("program test done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 6'h0; wd = 32'h0; pin = 1'b1; en = 1'b0;
        err_total = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_stream();
        t_audio();
        t_prog();
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end
endmodule
